// ---- tpc_pkg.sv ----
package tpc_pkg;
	localparam logic [7:0] TPC_OFS_CTRL = 8'h00;
	localparam logic [7:0] TPC_OFS_PASSWORD = 8'h04;
	localparam logic [7:0] TPC_OFS_CFG = 8'h08;
	localparam logic [7:0] TPC_OFS_LOCK = 8'h0C;
	localparam logic [7:0] TPC_OFS_UNTRACE = 8'h10;
	localparam logic [7:0] TPC_OFS_KILL = 8'h14;
	localparam logic [7:0] TPC_OFS_TUNE = 8'h18;
	localparam logic [7:0] TPC_OFS_STATUS = 8'h1C;
	localparam logic [7:0] TPC_OFS_PC = 8'h20;
	localparam logic [7:0] TPC_OFS_CRC = 8'h24;
	localparam logic [7:0] TPC_OFS_EPC0 = 8'h40;
	// Config word bit positions (MSB-first bit address 40h..4Fh)
	localparam int TPC_CFG_RANGE_SMALL = 4;
	localparam int TPC_CFG_RANGE_LARGE = 2;
	localparam int TPC_CFG_KILLBLK = 3;
	localparam int TPC_CFG_TUNEDIS = 0;
	// Reserved-memory word index of the tuning value
	localparam logic [7:0] TPC_TUNE_WORD_SMALL = 8'h14;
	localparam logic [7:0] TPC_TUNE_WORD_LARGE = 8'h1C;
	localparam logic [2:0] TPC_TUNE_MAX = 3'h4;
	localparam logic [2:0] TPC_TUNE_NEUTRAL = 3'h2;
	localparam logic [19:0] TPC_LOCK_OPEN = 20'hA0000;
	localparam logic [19:0] TPC_LOCK_PERMA_OPEN = 20'hF0000;
	localparam logic [19:0] TPC_LOCK_SECURED = 20'hA0280;
	localparam logic [19:0] TPC_LOCK_PERMA_SHUT = 20'hF03C0;
	localparam logic [7:0] TPC_ERR_NOT_SUPPORTED = 8'h01;
	localparam logic [7:0] TPC_ERR_OTHER = 8'h00;
	localparam logic [1:0] TPC_RANGE_NORMAL = 2'h0;
	localparam logic [1:0] TPC_RANGE_INVERT = 2'h1;
	localparam logic [1:0] TPC_RANGE_SHORT = 2'h2;
	localparam logic [15:0] TPC_CRC_POLY = 16'h1021;
	localparam logic [15:0] TPC_CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] TPC_PC_RESET = 16'h3400;
	localparam int TPC_ST_ERRV = 8;
	localparam int TPC_ST_KILLED = 9;
	localparam int TPC_ST_CRCBUSY = 10;
	localparam int TPC_ST_RANGE = 11;
	localparam int TPC_ST_INVERT = 12;
	localparam int TPC_ST_KSTAGE = 13;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} tpc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tpc_apb_rsp_t;

	typedef struct packed {
		logic range_short;
		logic [2:0] cap_code;
		logic tag_killed;
		logic crc_ready;
	} tpc_tag_out_t;
endpackage

// ---- tpc_core.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Lock needs equal password settings, else error
// - A0000/F0000 leave passwords open, readable
// - A0280 allows password access only secured
// - F03C0 blocks password access from everywhere
// - Other-memory lock bits accepted when consistent
// - Range flag writable secured, nonzero password
// - Range flag resets zero, zero means full
// - Range flag one gives short range
// - Untraceable range honoured secured, nonzero password
// - Range field 10 stores one, short
// - Range field 00 stores zero, normal
// - Range field 01 inverts until the next range write or power loss
// - Tuning flags in word 4, value word
// - Tuning value 0..4 maps capacitance offsets
// - Tuning value readable, writes ignored
// - Tuning disabled gives zero offset, readback kept
// - Tuning disable resets zero, zero re-enables
// - Kill-block flag secured write, sticky one
// - Kill-block zero allows kill with password
// - Kill-block set answers second kill Other
// - EPC bank holds CRC, PC, EPC
// - CRC over PC and L words at power-up
// - Flags written together; range and tuning rewritable
// - Range bit 4Bh/4Dh, tuning 4Fh
// - Zero password refuses kill
module tpc_core #(
	parameter bit LARGE = 1'b1,
	parameter int EPC_WORDS = 8,
	parameter logic [15:0] PC_RESET = tpc_pkg::TPC_PC_RESET
) (
	input wire logic pclk, // APB clock
	input wire logic presetn, // Power-up reset, active low
	input wire logic pce, // Clock enable, freezes all state
	input wire tpc_pkg::tpc_apb_req_t apb_req, // APB request
	output tpc_pkg::tpc_apb_rsp_t apb_rsp, // APB answer
	input wire logic [2:0] tune_meas, // Tuner result from front end
	output tpc_pkg::tpc_tag_out_t tag_out // Range, capacitance, kill, CRC
);
	import tpc_pkg::*;

	typedef struct packed {
		tpc_apb_rsp_t rsp;
		logic secured;
		logic [31:0] pw;
		logic pw_lock;
		logic pw_perma;
		logic range_flag;
		logic range_inv;
		logic tune_dis;
		logic kill_blk;
		logic kill_stage;
		logic killed;
		logic range_out;
		logic crc_done;
		logic [7:0] err_code;
		logic err_valid;
		logic [2:0] tune_s1;
		logic [2:0] tune_s2;
		logic [2:0] cap_code;
		logic [15:0] pc;
		logic [EPC_WORDS-1:0][15:0] epc;
		logic [15:0] crc;
		logic crc_busy;
		logic [3:0] crc_bit;
		logic [5:0] crc_word;
	} tpc_state_t;

	tpc_state_t state_ff;
	tpc_state_t nxt_state;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[15] ^ b;
		crc_step = {c[14:0], 1'b0} ^ (fb ? TPC_CRC_POLY : 16'h0000);
	endfunction

	// Password access check for current lock and session
	function automatic logic pw_ok(input logic lk, input logic pm, input logic sec);
		if (sec) begin
			pw_ok = !(lk && pm);
		end else begin
			pw_ok = !lk;
		end
	endfunction

	// Tuner codes above the top step are clamped, never passed on
	function automatic logic [2:0] tune_clamp(input logic [2:0] v);
		if (v > TPC_TUNE_MAX) begin
			tune_clamp = TPC_TUNE_MAX;
		end else begin
			tune_clamp = v;
		end
	endfunction

	// EPC window decode, shared by read and write paths
	function automatic logic epc_hit(input logic [7:0] adr);
		epc_hit = (adr >= TPC_OFS_EPC0) && (adr[1:0] == 2'b00) && (6'((adr - TPC_OFS_EPC0) >> 2) < 6'(EPC_WORDS));
	endfunction

	logic setup_hit;
	logic done_hit;
	logic wr_done;
	logic [7:0] a;
	logic [31:0] d;
	logic [15:0] cur_word;
	logic [5:0] epc_len;
	logic [2:0] tune_rd;
	logic pw_nz;
	logic eff_range;
	logic [5:0] epc_idx;
	int rng_bit;

	always_comb begin
		nxt_state = state_ff;
		a = apb_req.paddr;
		d = apb_req.pwdata;
		setup_hit = apb_req.psel && apb_req.penable && !state_ff.rsp.pready;
		done_hit = apb_req.psel && apb_req.penable && state_ff.rsp.pready;
		wr_done = done_hit && apb_req.pwrite && !state_ff.rsp.pslverr;
		pw_nz = (state_ff.pw != 32'h0000_0000);
		tune_rd = tune_clamp(state_ff.tune_s2);
		rng_bit = LARGE ? TPC_CFG_RANGE_LARGE : TPC_CFG_RANGE_SMALL;
		epc_idx = 6'((a - TPC_OFS_EPC0) >> 2);
		// Length field of the stored PC sets the CRC span
		epc_len = {1'b0, state_ff.pc[15:11]};
		cur_word = (state_ff.crc_word == 6'h00) ? state_ff.pc : state_ff.epc[state_ff.crc_word - 6'h01];

		// Two-flop synchroniser; only the second stage feeds logic
		nxt_state.tune_s1 = tune_meas;
		nxt_state.tune_s2 = state_ff.tune_s1;

		// CRC over PC then L EPC words, MSB first
		// power-up CRC walk
		if (state_ff.crc_busy) begin
			nxt_state.crc = crc_step(state_ff.crc, cur_word[4'hF - state_ff.crc_bit]);
			nxt_state.crc_bit = state_ff.crc_bit + 4'h1;
			if (state_ff.crc_bit == 4'hF) begin
				nxt_state.crc_word = state_ff.crc_word + 6'h01;
				if (state_ff.crc_word >= epc_len || state_ff.crc_word >= 6'(EPC_WORDS)) begin
					nxt_state.crc_busy = 1'b0;
					nxt_state.crc = ~crc_step(state_ff.crc, cur_word[4'hF - state_ff.crc_bit]);
				end
			end
		end

		// Answer in the second access cycle, two cycles after setup; data held until completion
		nxt_state.rsp.pready = 1'b0;
		if (setup_hit) begin
			nxt_state.rsp.pready = 1'b1;
			nxt_state.rsp.pslverr = 1'b0;
			nxt_state.rsp.prdata = 32'h0000_0000;
			unique case (a)
				TPC_OFS_CTRL: begin
					nxt_state.rsp.prdata = {31'h0, state_ff.secured};
				end
				TPC_OFS_PASSWORD: begin
					if (pw_ok(state_ff.pw_lock, state_ff.pw_perma, state_ff.secured)) begin
						nxt_state.rsp.prdata = state_ff.pw;
					end else begin
						nxt_state.rsp.pslverr = 1'b1;
					end
				end
				TPC_OFS_CFG: begin
					nxt_state.rsp.prdata[rng_bit] = state_ff.range_flag;
					nxt_state.rsp.prdata[TPC_CFG_TUNEDIS] = state_ff.tune_dis;
					nxt_state.rsp.prdata[TPC_CFG_KILLBLK] = LARGE && state_ff.kill_blk;
				end
				TPC_OFS_LOCK: begin
					nxt_state.rsp.prdata = {30'h0, state_ff.pw_perma, state_ff.pw_lock};
				end
				TPC_OFS_UNTRACE: begin
					nxt_state.rsp.prdata = 32'h0000_0000;
				end
				TPC_OFS_KILL: begin
					nxt_state.rsp.prdata = 32'h0000_0000;
				end
				// readback shows tuner choice even when disabled
				TPC_OFS_TUNE: begin
					nxt_state.rsp.prdata = {29'h0, tune_rd};
				end
				TPC_OFS_STATUS: begin
					nxt_state.rsp.prdata[7:0] = state_ff.err_code;
					nxt_state.rsp.prdata[TPC_ST_ERRV] = state_ff.err_valid;
					nxt_state.rsp.prdata[TPC_ST_KILLED] = state_ff.killed;
					nxt_state.rsp.prdata[TPC_ST_CRCBUSY] = state_ff.crc_busy;
					nxt_state.rsp.prdata[TPC_ST_RANGE] = state_ff.range_out;
					nxt_state.rsp.prdata[TPC_ST_INVERT] = state_ff.range_inv;
					nxt_state.rsp.prdata[TPC_ST_KSTAGE] = state_ff.kill_stage;
				end
				TPC_OFS_PC: begin
					nxt_state.rsp.prdata = {16'h0000, state_ff.pc};
				end
				TPC_OFS_CRC: begin
					nxt_state.rsp.prdata = {16'h0000, state_ff.crc};
				end
				default: begin
					if (epc_hit(a)) begin
						nxt_state.rsp.prdata = {16'h0000, state_ff.epc[epc_idx]};
					end else begin
						nxt_state.rsp.pslverr = 1'b1;
					end
				end
			endcase
			// Password write refused under the same lock test
			if (apb_req.pwrite && a == TPC_OFS_PASSWORD) begin
				nxt_state.rsp.pslverr = !pw_ok(state_ff.pw_lock, state_ff.pw_perma, state_ff.secured);
			end
		end

		// Writes take effect at the completing edge only
		if (wr_done) begin
			unique case (a)
				TPC_OFS_CTRL: begin
					nxt_state.secured = d[0];
				end
				TPC_OFS_PASSWORD: begin
					nxt_state.pw = d;
				end
				TPC_OFS_CFG: begin
					// all flags in one word write
					if (state_ff.secured) begin
						if (pw_nz) begin
							nxt_state.range_flag = d[rng_bit];
							nxt_state.range_inv = 1'b0;
						end
						nxt_state.tune_dis = d[TPC_CFG_TUNEDIS];
						// kill-block only ever goes to one
						if (LARGE && d[TPC_CFG_KILLBLK]) begin
							nxt_state.kill_blk = 1'b1;
						end
					end
				end
				TPC_OFS_LOCK: begin
					// kill and access fields must agree
					if (d[19:18] != d[17:16] || d[9:8] != d[7:6]) begin
						nxt_state.err_code = TPC_ERR_NOT_SUPPORTED;
						nxt_state.err_valid = 1'b1;
						// Permanent setting: only the same lock state is accepted
					end else if (state_ff.pw_perma && d[19] && d[9] != state_ff.pw_lock) begin
						nxt_state.err_code = TPC_ERR_NOT_SUPPORTED;
						nxt_state.err_valid = 1'b1;
					end else if (!state_ff.pw_perma) begin
						// A0000 / F0000 leave passwords open
						if (d[19]) begin
							nxt_state.pw_lock = d[9];
						end
						if (d[18]) begin
							nxt_state.pw_perma = d[8];
						end
					end
				end
				TPC_OFS_UNTRACE: begin
					// honoured only secured with nonzero password
					if (state_ff.secured && pw_nz) begin
						unique case (d[1:0])
							TPC_RANGE_SHORT: begin
								nxt_state.range_flag = 1'b1;
								nxt_state.range_inv = 1'b0;
							end
							TPC_RANGE_NORMAL: begin
								nxt_state.range_flag = 1'b0;
								nxt_state.range_inv = 1'b0;
							end
							TPC_RANGE_INVERT: begin
								nxt_state.range_inv = 1'b1;
							end
							default: begin
								nxt_state.range_inv = state_ff.range_inv;
							end
						endcase
					end
				end
				TPC_OFS_KILL: begin
					if (!state_ff.killed) begin
						if (!state_ff.kill_stage) begin
							// First write only arms; its data is ignored
							nxt_state.kill_stage = 1'b1;
						end else begin
							nxt_state.kill_stage = 1'b0;
							if (state_ff.kill_blk) begin
								nxt_state.err_code = TPC_ERR_OTHER;
								nxt_state.err_valid = 1'b1;
							end else if (!pw_nz) begin
								nxt_state.err_code = TPC_ERR_OTHER;
								nxt_state.err_valid = 1'b1;
							end else if (d == state_ff.pw) begin
								nxt_state.killed = 1'b1;
							end
						end
					end
				end
				TPC_OFS_TUNE: begin
					// Read-only word: the access completes, nothing changes
				end
				TPC_OFS_STATUS: begin
					if (d[TPC_ST_ERRV]) begin
						nxt_state.err_valid = 1'b0;
					end
				end
				// PC and EPC words stored apart from CRC
				TPC_OFS_PC: begin
					nxt_state.pc = d[15:0];
				end
				TPC_OFS_CRC: begin
					// Computed at power-up only; bus writes dropped
				end
				default: begin
					if (epc_hit(a)) begin
						nxt_state.epc[epc_idx] = d[15:0];
					end
				end
			endcase
			// Error raised in the same cycle as a clear still wins
			if (a == TPC_OFS_STATUS && state_ff.err_valid == 1'b0 && nxt_state.err_valid) begin
				nxt_state.err_valid = 1'b1;
			end
		end

		// effective range, inverse applied
		// Taken from the next flags so the pin flop keeps step with them
		eff_range = nxt_state.range_flag ^ nxt_state.range_inv;
		nxt_state.range_out = eff_range;
		// completion flag registered for the ready pin
		nxt_state.crc_done = !nxt_state.crc_busy;
		// codes 0..4 map to offsets; disabled is neutral
		if (state_ff.tune_dis) begin
			nxt_state.cap_code = TPC_TUNE_NEUTRAL;
		end else begin
			nxt_state.cap_code = tune_rd;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Power-up values; the CRC walk starts on the first enabled edge
			state_ff <= '0;
			state_ff.pc <= PC_RESET;
			state_ff.crc <= TPC_CRC_PRESET;
			state_ff.crc_busy <= 1'b1;
			state_ff.cap_code <= TPC_TUNE_NEUTRAL;
		end else if (pce) begin
			// Enable low freezes every field, the bus answer too
			state_ff <= nxt_state;
		end
	end

	// Every pin is a plain flop, no gate after it
	assign apb_rsp = state_ff.rsp;
	assign tag_out.range_short = state_ff.range_out;
	assign tag_out.cap_code = state_ff.cap_code;
	assign tag_out.tag_killed = state_ff.killed;
	assign tag_out.crc_ready = state_ff.crc_done;
endmodule

// ---- tpc_core_asserts.sv ----
`timescale 1ns/1ps
module tpc_core_asserts #(
	parameter int EPC_WORDS = 8,
	parameter logic [15:0] PC_RESET = tpc_pkg::TPC_PC_RESET
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Power-up reset, active low
	input wire logic pce, // Clock enable
	input wire tpc_pkg::tpc_apb_req_t apb_req, // APB request
	input wire tpc_pkg::tpc_apb_rsp_t apb_rsp, // APB answer
	input wire logic [2:0] tune_meas, // Tuner result
	input wire tpc_pkg::tpc_tag_out_t tag_out // Tag outputs
);
	import tpc_pkg::*;
	localparam int L_WORDS = (PC_RESET[15:11] < EPC_WORDS) ? PC_RESET[15:11] : EPC_WORDS;
	localparam int CRC_CYC = 16 * (1 + L_WORDS);
	logic [11:0] cyc_ff;
	logic wdone;
	assign wdone = apb_rsp.pready && apb_req.psel && apb_req.penable && apb_req.pwrite;
	// Enabled edges since release, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cyc_ff <= 12'h000;
		else if (pce && cyc_ff != 12'hFFF) cyc_ff <= cyc_ff + 12'h001;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		pce && apb_req.psel && apb_req.penable && !apb_rsp.pready;
	endsequence
	sequence s_untrace_keep;
		wdone && apb_req.paddr == TPC_OFS_UNTRACE && apb_req.pwdata[1:0] == 2'h3;
	endsequence
	a_ready_wait: assert property (s_access |=> apb_rsp.pready) else $error("no answer after one wait state");
	a_ready_pulse: assert property (pce && apb_rsp.pready |=> !apb_rsp.pready) else $error("ready longer than a cycle");
	a_ready_cause: assert property (apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable)) else $error("stray ready");
	a_setup_quiet: assert property (apb_req.psel && !apb_req.penable |=> !apb_rsp.pready) else $error("ready too early");
	a_cap_bound: assert property (tag_out.cap_code <= 3'h4) else $error("capacitance code out of range");
	a_kill_sticky: assert property (tag_out.tag_killed |=> tag_out.tag_killed) else $error("killed state left");
	a_kill_cause: assert property ($rose(tag_out.tag_killed) |-> $past(wdone && apb_req.paddr == TPC_OFS_KILL))
		else $error("killed without kill write");
	a_range_cause: assert property ($changed(tag_out.range_short) |->
		$past(wdone && (apb_req.paddr == TPC_OFS_CFG || apb_req.paddr == TPC_OFS_UNTRACE)))
		else $error("range changed without write");
	a_untrace_noop: assert property (s_untrace_keep |=> $stable(tag_out.range_short) ##1 $stable(tag_out.range_short))
		else $error("range field 11 changed range");
	a_crc_time: assert property ($rose(tag_out.crc_ready) |-> cyc_ff inside {[CRC_CYC - 1:CRC_CYC + 1]})
		else $error("checksum ready at wrong time");
endmodule

// ---- tpc_apb_master.sv ----
`timescale 1ns/1ps
module tpc_apb_master (
	input wire logic pclk, // Clock
	output tpc_pkg::tpc_apb_req_t req, // Request to the block
	input wire tpc_pkg::tpc_apb_rsp_t rsp // Answer from the block
);
	import tpc_pkg::*;
	initial req = '0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] res);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		res = {rsp.pslverr, rsp.prdata};
		// Released lines must not keep the last value
		req <= '{1'b0, 1'b0, ~w, ~a, ~d};
		@(posedge pclk);
	endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
	import tpc_pkg::*;
	typedef struct packed {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] m; logic [31:0] e; logic r;} tpc_row_t;
	localparam logic [7:0] CT = TPC_OFS_CTRL, PW = TPC_OFS_PASSWORD, CF = TPC_OFS_CFG, LK = TPC_OFS_LOCK;
	localparam logic [7:0] UN = TPC_OFS_UNTRACE, KL = TPC_OFS_KILL, TU = TPC_OFS_TUNE, ST = TPC_OFS_STATUS;
	localparam logic [31:0] P1 = 32'h12345678, FF = 32'hFFFFFFFF, Z = 32'h0;
	logic pclk, presetn, pce;
	logic [2:0] tune_meas;
	tpc_apb_req_t apb_req;
	tpc_apb_rsp_t apb_rsp;
	tpc_tag_out_t tag_out;
	logic [32:0] res;
	int mismatches, n_tests, cyc;
	logic [2:0] tv [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	tpc_row_t rows [$] = '{
		'{CF, 32'h4, ST, 32'h800, Z, 1'b0},
		'{CT, 32'h1, CT, 32'h1, 32'h1, 1'b0},
		'{ST, 32'h100, TU, 32'h7, 32'h3, 1'b0},
		'{TU, 32'h7, TU, 32'h7, 32'h3, 1'b0},
		'{KL, Z, ST, Z, Z, 1'b0},
		'{KL, Z, ST, 32'h1FF, 32'h100, 1'b0},
		'{CF, 32'h4, ST, 32'h800, Z, 1'b0},
		'{PW, P1, PW, FF, P1, 1'b0},
		'{CF, 32'h4, ST, 32'h800, 32'h800, 1'b0},
		'{CF, 32'h1, ST, 32'h800, Z, 1'b0},
		'{UN, 32'h2, ST, 32'h800, 32'h800, 1'b0},
		'{UN, 32'h3, ST, 32'h800, 32'h800, 1'b0},
		'{UN, 32'h1, ST, 32'h1800, 32'h1000, 1'b0},
		'{UN, Z, ST, 32'h1800, Z, 1'b0},
		'{CF, 32'h8, CF, 32'h8, 32'h8, 1'b0},
		'{CF, Z, CF, 32'h8, 32'h8, 1'b0},
		'{ST, 32'h100, 8'h3C, Z, Z, 1'b1},
		'{KL, Z, ST, Z, Z, 1'b0},
		'{KL, P1, ST, 32'h3FF, 32'h100, 1'b0},
		'{ST, 32'h100, ST, 32'h100, Z, 1'b0},
		'{LK, 32'hA0200, ST, 32'h1FF, 32'h101, 1'b0},
		'{ST, 32'h100, ST, 32'h100, Z, 1'b0},
		'{LK, 32'hA0280, ST, 32'h100, Z, 1'b0},
		'{CT, Z, PW, Z, Z, 1'b1},
		'{CT, 32'h1, PW, FF, P1, 1'b0},
		'{LK, 32'hA0000, ST, 32'h100, Z, 1'b0},
		'{CT, Z, PW, FF, P1, 1'b0},
		'{CT, 32'h1, CT, 32'h1, 32'h1, 1'b0},
		'{LK, 32'hF03C0, PW, Z, Z, 1'b1},
		'{CT, Z, PW, Z, Z, 1'b1},
		'{CT, 32'h1, ST, 32'h100, Z, 1'b0},
		'{LK, 32'hFC3F0, ST, 32'h100, Z, 1'b0}
	};
	tpc_core tpc_core_inst (.pclk(pclk), .presetn(presetn), .pce(pce), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.tune_meas(tune_meas), .tag_out(tag_out));
	tpc_apb_master tpc_apb_master_inst (.pclk(pclk), .req(apb_req), .rsp(apb_rsp));
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		tpc_apb_master_inst.xfer(1'b1, a, d, res);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic r);
		tpc_apb_master_inst.xfer(1'b0, a, Z, res);
		chk({res[32], res[31:0] & m}, {r, e});
	endtask
	function automatic logic [15:0] crc_of(input logic [15:0] pc, input int n);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 0; i <= n; i++)
			for (int b = 15; b >= 0; b--)
				c = (c[15] ^ (i == 0 && pc[b])) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
		return ~c;
	endfunction
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		presetn = 1'b0;
		pce = 1'b1;
		tune_meas = 3'h3;
		repeat (3) @(posedge pclk);
		chk(tag_out, 6'h08);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rdc(rows[i].ra, rows[i].m, rows[i].e, rows[i].r);
		end
		for (int i = 0; i < 6; i++) begin
			tune_meas <= tv[i];
			repeat (6) @(posedge pclk);
			chk(tag_out.cap_code, (tv[i] > 3'h4) ? 3'h4 : tv[i]);
		end
		pce <= 1'b0;
		tune_meas <= 3'h1;
		repeat (6) @(posedge pclk);
		chk(tag_out.cap_code, 3'h4);
		pce <= 1'b1;
		tune_meas <= 3'h7;
		wr(CF, 32'h5);
		repeat (2) @(posedge pclk);
		chk(tag_out.cap_code, 3'h2);
		chk(tag_out.range_short, 1'b1);
		rdc(TU, 32'h7, 32'h4, 1'b0);
		wr(CF, Z);
		repeat (2) @(posedge pclk);
		chk(tag_out.cap_code, 3'h4);
		chk(tag_out.range_short, 1'b0);
		chk(tag_out.crc_ready, 1'b1);
		rdc(TPC_OFS_CRC, 32'hFFFF, {16'h0, crc_of(16'h3400, 6)}, 1'b0);
		rdc(TPC_OFS_PC, 32'hFFFF, 32'h3400, 1'b0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(tag_out, 6'h08);
		presetn <= 1'b1;
		@(posedge pclk);
		wr(CT, 32'h1);
		wr(PW, 32'h5A5A5A5A);
		wr(LK, 32'hF0000);
		wr(CT, Z);
		rdc(PW, FF, 32'h5A5A5A5A, 1'b0);
		wr(CT, 32'h1);
		wr(KL, Z);
		wr(KL, 32'h5A5A5A5A);
		repeat (2) @(posedge pclk);
		chk(tag_out.tag_killed, 1'b1);
		conclude();
	end
endmodule
bind tpc_core tpc_core_asserts #(.EPC_WORDS(EPC_WORDS), .PC_RESET(PC_RESET)) tpc_core_asserts_inst (.pclk(pclk),
	.presetn(presetn), .pce(pce), .apb_req(apb_req), .apb_rsp(apb_rsp), .tune_meas(tune_meas), .tag_out(tag_out));
